//--- inc/ldk_defs.vh
// Shared constants for the dimming and key-scan block
`ifndef LDK_DEFS_VH
`define LDK_DEFS_VH

// =====================================================================
// Command byte decoding
`define LDK_CMD_DIM_NIB     4'he
`define LDK_CMD_PIN_NIB     4'ha
`define LDK_PIN_SEL_BIT     0
`define LDK_PIN_ACT_BIT     1

// =====================================================================
// Read pointer locations
`define LDK_ADDR_KEY_FIRST  8'h40
`define LDK_ADDR_KEY_LAST   8'h45
`define LDK_ADDR_FLAG       8'h60

// =====================================================================
// Reset values
`define LDK_LEVEL_RST       4'hf
`define LDK_PIN_SEL_RST     1'b0
`define LDK_PIN_ACT_RST     1'b0

// =====================================================================
// Timing
`define LDK_CLK_MHZ         25
`define LDK_SUB_US          64
`define LDK_SLOT_US         1024
`define LDK_SUB_CYC         (`LDK_SUB_US * `LDK_CLK_MHZ)
`define LDK_SUBS_PER_SLOT   16
`define LDK_DISP_SLOTS      8
`define LDK_KEY_SLOT        4'h8

// =====================================================================
// Key matrix geometry
`define LDK_KEYS_PER_LINE   13
`define LDK_MAX_LINES       3

`endif

//--- rtl/ldk_slot_timer.v
// Sub-slot, slot and key-scan cycle timer
`timescale 1ns/1ps
`include "ldk_defs.vh"

module ldk_slot_timer #(
  parameter SUB_CYC = `LDK_SUB_CYC
) (
  input  wire       clock_i,
  input  wire       srst_i,
  output reg  [3:0] slot_o,
  output reg  [3:0] sub_o,
  output wire       sub_end_o,
  output wire       slot_end_o,
  output wire       cyc_end_o
);

  // =====================================================================
  // Cycle counter within one sixteenth of a slot
  reg  [15:0] cnt_r;
  wire        sub_end;

  assign sub_end    = (cnt_r == SUB_CYC[15:0] - 16'h0001);
  assign sub_end_o  = sub_end;
  assign slot_end_o = sub_end & (sub_o == 4'hf);
  assign cyc_end_o  = slot_end_o & (slot_o == `LDK_KEY_SLOT);

  always @(posedge clock_i) begin
    if (srst_i) begin
      cnt_r  <= 16'h0000;
      sub_o  <= 4'h0;
      slot_o <= 4'h0;
    end else begin
      cnt_r <= sub_end ? 16'h0000 : cnt_r + 16'h0001;
      if (sub_end) begin
        sub_o <= sub_o + 4'h1;
        if (sub_o == 4'hf) begin
          // Eight display slots then one key-scan slot
          slot_o <= (slot_o == `LDK_KEY_SLOT) ? 4'h0 : slot_o + 4'h1;
        end
      end
    end
  end

endmodule // ldk_slot_timer

//--- rtl/ldk_key_debounce.v
// Two-cycle key debounce with once-only press reporting
`timescale 1ns/1ps

module ldk_key_debounce #(
  parameter NKEYS = 39
) (
  input  wire             clock_i,
  input  wire             srst_i,
  input  wire             cyc_end_i,
  input  wire [NKEYS-1:0] pressed_i,
  output reg  [NKEYS-1:0] new_key_o
);

  // =====================================================================
  // Previous-cycle presses and keys already reported
  reg [NKEYS-1:0] prev_r;
  reg [NKEYS-1:0] latched_r;
  wire [NKEYS-1:0] confirmed;

  assign confirmed = pressed_i & prev_r;

  always @(posedge clock_i) begin
    if (srst_i) begin
      prev_r    <= {NKEYS{1'b0}};
      latched_r <= {NKEYS{1'b0}};
      new_key_o <= {NKEYS{1'b0}};
    end else begin
      new_key_o <= {NKEYS{1'b0}};
      if (cyc_end_i) begin
        prev_r    <= pressed_i;
        // A key needs two cycles pressed before it counts
        new_key_o <= confirmed & ~latched_r; // RQ7 RQ10
        // Latch holds until the key is seen released
        latched_r <= (latched_r | confirmed) & pressed_i; // RQ16
      end
    end
  end

endmodule // ldk_key_debounce

//--- rtl/ldk_dim_keyscan.v
// Dimming PWM, cathode multiplexing and key-scan top
`timescale 1ns/1ps
`include "ldk_defs.vh"

// Summary of operation
// RQ1: Command nibble 1110 sets level N; rows lit (N+1)/16 of slot; reset full.
// RQ2: Cathodes pulse low in turn; low time 64us to 1024us with level.
// RQ3: One to three scan lines; interrupt pin optional, flag pollable instead.
// RQ4: Cathode lines 1 to 3 driven high as scan rows during key scan.
// RQ5: Thirty-nine keys only when all three scan lines are enabled.
// RQ6: Scanning repeats on its own; full debounce spans about 20 ms.
// RQ7: Accept press only for released key seen pressed in both samples.
// RQ8: Any combination of simultaneous presses is recorded.
// RQ9: Interrupt pin active low when polarity bit 0, high when 1.
// RQ10: New presses update key data and interrupt after two scan cycles.
// RQ11: Interrupt changes on first accepted key; no further toggling while pending.
// RQ12: Reading all key bytes clears key data, flag and interrupt pin.
// RQ13: Location 60H reads the pending flag in all eight bits.
// RQ14: Nibble 1010 selects row or interrupt use; bit 1 sets polarity.
// RQ15: Key data at 40H to 45H, two bytes per line, writes ignored.
// RQ16: Held key reported once; must be released before reporting again.
// RQ17: Host reads all six key bytes from 40H after each interrupt.
// RQ18: New brightness level applies from the next slot boundary.
module ldk_dim_keyscan #(
  parameter SUB_CYC    = `LDK_SUB_CYC,
  parameter SCAN_LINES = `LDK_MAX_LINES
) (
  input  wire        clock_i,
  input  wire        srst_i,
  input  wire        cmd_stb_i,
  input  wire [7:0]  cmd_byte_i,
  input  wire        rd_stb_i,
  input  wire [7:0]  rd_addr_i,
  output reg  [7:0]  rd_data_o,
  output reg         rd_ack_o,
  input  wire [12:0] key_ret_i,
  output reg  [7:0]  cathode_o,
  output reg  [7:0]  cathode_oe_o,
  output reg         row_gate_o,
  output reg         shared_irq_row_pin_o,
  output reg         shared_irq_row_pin_oe_o,
  output reg         pending_flag_o
);

  localparam NK  = `LDK_KEYS_PER_LINE;
  localparam NKT = `LDK_KEYS_PER_LINE * `LDK_MAX_LINES;

  // =====================================================================
  // Key byte decode, used by the read path and the read tracker
  function [2:0] key_index;
    input [7:0] addr;
    begin
      key_index = addr[2:0];
    end
  endfunction

  function is_key_addr;
    input [7:0] addr;
    begin
      is_key_addr = (addr >= `LDK_ADDR_KEY_FIRST) && (addr <= `LDK_ADDR_KEY_LAST);
    end
  endfunction

  // =====================================================================
  // Timer
  wire [3:0] slot;
  wire [3:0] sub;
  wire       sub_end;
  wire       slot_end;
  wire       cyc_end;

  // Nine slots a frame: eight display slots, then the key slot
  ldk_slot_timer #(
    .SUB_CYC (SUB_CYC)
  ) u_timer (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .slot_o     (slot),
    .sub_o      (sub),
    .sub_end_o  (sub_end),
    .slot_end_o (slot_end),
    .cyc_end_o  (cyc_end)
  );

  // =====================================================================
  // Command registers
  reg  [3:0] level_pend_r;
  reg  [3:0] level_r;
  reg        pin_sel_r;
  reg        pin_act_r;

  always @(posedge clock_i) begin
    if (srst_i) begin
      level_pend_r <= `LDK_LEVEL_RST; // RQ1
      level_r      <= `LDK_LEVEL_RST; // RQ1
      pin_sel_r    <= `LDK_PIN_SEL_RST;
      pin_act_r    <= `LDK_PIN_ACT_RST;
    end else begin
      if (cmd_stb_i) begin
        case (cmd_byte_i[7:4])
          `LDK_CMD_DIM_NIB: begin
            level_pend_r <= cmd_byte_i[3:0]; // RQ1
          end
          `LDK_CMD_PIN_NIB: begin
            pin_sel_r <= cmd_byte_i[`LDK_PIN_SEL_BIT]; // RQ14
            pin_act_r <= cmd_byte_i[`LDK_PIN_ACT_BIT]; // RQ14
          end
          default: begin
            // Other commands belong elsewhere; no key data is writable
            level_pend_r <= level_pend_r; // RQ15
          end
        endcase
      end
      // Applying only at the boundary avoids a cut-short pulse
      if (slot_end) begin
        level_r <= level_pend_r; // RQ18
      end
    end
  end

  // =====================================================================
  // PWM window and cathode drive
  wire       disp_slot;
  wire       key_slot;
  wire       pwm_on;
  wire [1:0] scan_line;
  wire       line_en;

  assign disp_slot = (slot < `LDK_KEY_SLOT);
  assign key_slot  = (slot == `LDK_KEY_SLOT);
  // Level 0 still lights one sixteenth; there is no off setting
  assign pwm_on    = disp_slot & (sub <= level_r); // RQ1 RQ2
  assign scan_line = sub[3:2];
  assign line_en   = key_slot & (scan_line < SCAN_LINES[1:0]); // RQ3 RQ5

  reg  [7:0] cath_nxt;
  reg  [7:0] cath_oe_nxt;
  integer    c;

  always @* begin
    cath_nxt    = 8'hff;
    cath_oe_nxt = 8'h00;
    for (c = 0; c < 8; c = c + 1) begin
      if (pwm_on && (slot[2:0] == c[2:0])) begin
        cath_nxt[c]    = 1'b0; // RQ2
        cath_oe_nxt[c] = 1'b1; // RQ2
      end
    end
    if (line_en) begin
      // Cathode lines 1 to 3 double as the scan rows
      cath_oe_nxt[scan_line + 2'd1] = 1'b1; // RQ4
    end
  end

  // =====================================================================
  // Key return synchroniser and sampling
  reg  [12:0]    key_s1_r;
  reg  [12:0]    key_s2_r;
  wire [NKT-1:0] samp_a_all;
  wire [NKT-1:0] samp_b_all;
  wire           samp_a;
  wire           samp_b;

  assign samp_a = line_en & sub_end & (sub[1:0] == 2'd1);
  assign samp_b = line_en & sub_end & (sub[1:0] == 2'd3);

  // Only the second stage is read; the first may still be settling
  always @(posedge clock_i) begin
    if (srst_i) begin
      key_s1_r <= 13'h0000;
      key_s2_r <= 13'h0000;
    end else begin
      key_s1_r <= key_ret_i;
      key_s2_r <= key_s1_r;
    end
  end

  // One pair of sample registers per scan line
  genvar gl;
  generate
    for (gl = 0; gl < `LDK_MAX_LINES; gl = gl + 1) begin : g_line
      localparam integer LINE = gl;
      reg [NK-1:0] samp_a_r;
      reg [NK-1:0] samp_b_r;

      always @(posedge clock_i) begin
        if (srst_i) begin
          samp_a_r <= {NK{1'b0}};
          samp_b_r <= {NK{1'b0}};
        end else if (LINE < SCAN_LINES) begin // RQ5
          // Lines outside the scan range are never loaded
          if (samp_a && (scan_line == LINE[1:0])) begin
            samp_a_r <= key_s2_r; // RQ8
          end
          if (samp_b && (scan_line == LINE[1:0])) begin
            samp_b_r <= key_s2_r; // RQ8
          end
        end
      end

      assign samp_a_all[gl*NK +: NK] = samp_a_r;
      assign samp_b_all[gl*NK +: NK] = samp_b_r;
    end
  endgenerate

  // =====================================================================
  // Debounce, continuous without host action
  wire [NKT-1:0] new_key;

  ldk_key_debounce #(
    .NKEYS (NKT)
  ) u_debounce (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .cyc_end_i (cyc_end), // RQ6
    .pressed_i (samp_a_all & samp_b_all), // RQ7
    .new_key_o (new_key)
  );

  // =====================================================================
  // Key store, read tracking and pending flag
  reg  [NKT-1:0] key_data_r;
  reg  [5:0]     rd_seen_r;
  reg            flag_r;
  wire           rd_key;
  wire [5:0]     rd_seen_now;
  wire           all_read;

  assign rd_key      = rd_stb_i & is_key_addr(rd_addr_i);
  // Bytes may come in any order; the flag location does not count
  assign rd_seen_now = rd_seen_r | (rd_key ? (6'h01 << key_index(rd_addr_i)) : 6'h00);
  assign all_read    = rd_key & (rd_seen_now == 6'h3f);

  always @(posedge clock_i) begin
    if (srst_i) begin
      key_data_r <= {NKT{1'b0}};
      rd_seen_r  <= 6'h00;
      flag_r     <= 1'b0;
    end else begin
      if (all_read) begin
        // A press landing on the clearing read is kept
        key_data_r <= new_key; // RQ12
        flag_r     <= |new_key; // RQ12
        rd_seen_r  <= 6'h00; // RQ12
      end else begin
        key_data_r <= key_data_r | new_key; // RQ8 RQ10
        flag_r     <= flag_r | (|new_key); // RQ11
        rd_seen_r  <= rd_seen_now;
      end
    end
  end

  // =====================================================================
  // Read data path
  reg  [7:0] rd_nxt;
  reg  [12:0] line_keys;

  always @* begin
    rd_nxt    = 8'h00;
    line_keys = 13'h0000;
    if (is_key_addr(rd_addr_i)) begin
      case (key_index(rd_addr_i) >> 1)
        3'd0: line_keys = key_data_r[0*NK +: NK];
        3'd1: line_keys = key_data_r[1*NK +: NK];
        3'd2: line_keys = key_data_r[2*NK +: NK];
        default: line_keys = 13'h0000;
      endcase
      rd_nxt = rd_addr_i[0] ? {3'h0, line_keys[12:8]} : line_keys[7:0]; // RQ15
    end else if (rd_addr_i == `LDK_ADDR_FLAG) begin
      rd_nxt = {8{flag_r}}; // RQ13
    end
  end

  // =====================================================================
  // Output registers
  always @(posedge clock_i) begin
    if (srst_i) begin
      rd_data_o               <= 8'h00;
      rd_ack_o                <= 1'b0;
      cathode_o               <= 8'hff;
      cathode_oe_o            <= 8'h00;
      row_gate_o              <= 1'b0;
      shared_irq_row_pin_o    <= 1'b0;
      shared_irq_row_pin_oe_o <= 1'b0;
      pending_flag_o          <= 1'b0;
    end else begin
      rd_ack_o       <= rd_stb_i;
      rd_data_o      <= rd_stb_i ? rd_nxt : rd_data_o;
      cathode_o      <= cath_nxt;
      cathode_oe_o   <= cath_oe_nxt;
      row_gate_o     <= pwm_on; // RQ1
      pending_flag_o <= flag_r; // RQ3
      // Push-pull in both modes; open-drain use needs gating outside
      shared_irq_row_pin_oe_o <= 1'b1;
      if (pin_sel_r) begin
        shared_irq_row_pin_o <= pin_act_r ? flag_r : ~flag_r; // RQ9 RQ11 RQ12
      end else begin
        shared_irq_row_pin_o <= pwm_on; // RQ14
      end
    end
  end

endmodule // ldk_dim_keyscan

//--- dv/ldk_key_matrix.sv
// Diode-isolated key switch matrix seen from the scan lines
`timescale 1ns/1ps
module ldk_key_matrix (
  input  wire [7:0]  cathode_i,
  input  wire [7:0]  cathode_oe_i,
  input  wire [38:0] keys_i,
  output wire [12:0] ret_o
);
  // ===================================================
  // Returns
  // Diodes stop ghosting; unselected returns sit on pull-downs
  wire [2:0] sel = cathode_i[3:1] & cathode_oe_i[3:1];
  assign ret_o = ({13{sel[0]}} & keys_i[12:0]) | ({13{sel[1]}} & keys_i[25:13])
               | ({13{sel[2]}} & keys_i[38:26]);
endmodule // ldk_key_matrix

//--- dv/ldk_dim_keyscan_chk.sv
// Port-level assertions for the dimming and key-scan top
`timescale 1ns/1ps
module ldk_dim_keyscan_chk (
  input wire        clock_i,
  input wire        srst_i,
  input wire        rd_stb_i,
  input wire [7:0]  rd_addr_i,
  input wire [7:0]  rd_data_o,
  input wire        rd_ack_o,
  input wire [7:0]  cathode_o,
  input wire [7:0]  cathode_oe_o,
  input wire        row_gate_o,
  input wire        shared_irq_row_pin_oe_o,
  input wire        pending_flag_o
);
  // ===================================================
  // Assertions
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence s_flag_rd;
    rd_stb_i && rd_addr_i == 8'h60 ##1 rd_ack_o;
  endsequence
  a_ack_follows: assert property (rd_stb_i |=> rd_ack_o) else $error("no ack");
  a_ack_alone: assert property (!rd_stb_i |=> !rd_ack_o) else $error("stray ack");
  a_flag_read: assert property (s_flag_rd |-> rd_data_o == {8{pending_flag_o}})
    else $error("flag byte");
  a_unmapped_zero: assert property (rd_stb_i && rd_addr_i != 8'h60 &&
    (rd_addr_i < 8'h40 || rd_addr_i > 8'h45) |=> rd_data_o == 8'h00) else $error("unmapped");
  a_one_cathode: assert property ($onehot0(cathode_oe_o)) else $error("two cathodes");
  a_scan_high: assert property (|(cathode_oe_o & cathode_o) |->
    (cathode_oe_o & 8'hf1) == 8'h00) else $error("scan line");
  a_gate_scan: assert property (row_gate_o |-> (cathode_oe_o & cathode_o) == 8'h00)
    else $error("row in scan");
  a_pin_driven: assert property (!srst_i |=> shared_irq_row_pin_oe_o) else $error("pin oe");
  a_flag_clear: assert property ($fell(pending_flag_o) |-> $past(rd_ack_o))
    else $error("flag fell");
endmodule // ldk_dim_keyscan_chk

//--- dv/ldk_dim_keyscan_tb.sv
// Self-checking bench for the dimming and key-scan top
`timescale 1ns/1ps
module ldk_dim_keyscan_tb;
  // ===================================================
  // Harness
  localparam SUB = 8;
  localparam FR = 9 * 16 * SUB;
  reg         clock_i = 1'b0;
  reg         srst_i = 1'b1;
  reg         cmd_stb_i = 1'b0;
  reg         rd_stb_i = 1'b0;
  reg  [7:0]  cmd_byte_i = 8'h00;
  reg  [7:0]  rd_addr_i = 8'h00;
  reg  [38:0] keys = 39'h0;
  reg  [31:0] seed = 32'd70131;
  reg  [7:0]  d;
  wire [7:0]  rd_data, cath, cath_oe;
  wire [12:0] ret;
  wire        ack, gate, pin, pin_oe, flag;
  int         n_fail = 0;
  int         checked = 0;
  int         i, n;
  always #20 clock_i = ~clock_i;
  ldk_dim_keyscan #(.SUB_CYC(SUB), .SCAN_LINES(3)) i_ldk_dim_keyscan (.clock_i(clock_i),
    .srst_i(srst_i), .cmd_stb_i(cmd_stb_i), .cmd_byte_i(cmd_byte_i), .rd_stb_i(rd_stb_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data), .rd_ack_o(ack), .key_ret_i(ret),
    .cathode_o(cath), .cathode_oe_o(cath_oe), .row_gate_o(gate), .shared_irq_row_pin_o(pin),
    .shared_irq_row_pin_oe_o(pin_oe), .pending_flag_o(flag));
  ldk_key_matrix i_ldk_key_matrix (.cathode_i(cath), .cathode_oe_i(cath_oe), .keys_i(keys),
    .ret_o(ret));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input [31:0] got, input [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task cmd(input [7:0] b);
    @(negedge clock_i);
    cmd_stb_i = 1'b1;
    cmd_byte_i = b;
    @(negedge clock_i);
    cmd_stb_i = 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] q);
    @(negedge clock_i);
    rd_stb_i = 1'b1;
    rd_addr_i = a;
    @(negedge clock_i);
    rd_stb_i = 1'b0;
    q = rd_data;
  endtask
  // Counts over any whole frame, so no alignment is needed
  task meas(input int lv);
    int g, lo, pm;
    g = 0;
    lo = 0;
    pm = 0;
    repeat (FR) begin
      @(negedge clock_i);
      g += gate;
      lo += |(cath_oe & ~cath);
      pm += (pin !== gate);
    end
    chk(g, 8 * (lv + 1) * SUB, "row width");
    chk(lo, 8 * (lv + 1) * SUB, "cathode low");
    chk(pm, 0, "row pin");
  endtask
  task press(input [38:0] m, input bit pol);
    reg [7:0] kb [0:5];
    int k;
    for (k = 0; k < 6; k++) kb[k] = 8'h00;
    for (k = 0; k < 39; k++) if (m[k]) kb[2 * (k / 13) + (k % 13) / 8][(k % 13) % 8] = 1'b1;
    keys = m;
    repeat (FR) @(negedge clock_i);
    chk(flag, 0, "early flag");
    repeat (3 * FR) @(negedge clock_i);
    chk(flag, 1, "key flag");
    chk(pin, pol, "irq on");
    rd(8'h60, d);
    chk(d, 8'hff, "flag byte");
    for (k = 0; k < 6; k++) begin
      rd(8'h40 + k[7:0], d);
      chk(d, kb[k], "key byte");
    end
    repeat (2) @(negedge clock_i);
    chk(flag, 0, "flag clear");
    chk(pin, !pol, "irq off");
    repeat (3 * FR) @(negedge clock_i);
    chk(flag, 0, "held repeat");
    keys = 39'h0;
    repeat (3 * FR) @(negedge clock_i);
    $display("test key press done");
  endtask
  task test_done;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ===================================================
  // Tests
  initial begin
    repeat (12) @(negedge clock_i);
    srst_i = 1'b0;
    rd(8'h60, d);
    chk(d, 8'h00, "flag reset");
    rd(8'h46, d);
    chk(d, 8'h00, "unmapped read");
    chk(pin_oe, 1, "pin oe");
    for (i = 0; i < 3; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? rnd() % 15 : 15;
      cmd({4'he, n[3:0]});
      cmd(8'h8f);
      repeat (FR) @(negedge clock_i);
      meas(n);
    end
    $display("test dimming done");
    cmd(8'ha3);
    press(39'h1 << (rnd() % 39), 1'b1);
    cmd(8'ha1);
    press((39'h1 << (rnd() % 13)) | (39'h1 << (26 + rnd() % 13)), 1'b0);
    test_done;
  end
  initial begin
    // Tests take about 26 frames; allow 40
    repeat (40 * FR) @(posedge clock_i);
    n_fail++;
    $display("BAD %0t watchdog", $time);
    test_done;
  end
endmodule // ldk_dim_keyscan_tb
bind ldk_dim_keyscan ldk_dim_keyscan_chk i_chk (.clock_i(clock_i), .srst_i(srst_i),
  .rd_stb_i(rd_stb_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o),
  .cathode_o(cathode_o), .cathode_oe_o(cathode_oe_o), .row_gate_o(row_gate_o),
  .shared_irq_row_pin_oe_o(shared_irq_row_pin_oe_o), .pending_flag_o(pending_flag_o));
